// ### include/cam_map.svh
// Register offsets, field positions, reset values and scaling figures of the monitor block
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH
`define CAM_OFF_MASK5 8'h21
`define CAM_OFF_IDENT 8'h22
`define CAM_OFF_CTRL1 8'h23
`define CAM_OFF_CTRL2 8'h24
`define CAM_OFF_ICUR_HI 8'h25
`define CAM_OFF_ICUR_LO 8'h26
`define CAM_OFF_VIN_HI 8'h27
`define CAM_OFF_VIN_LO 8'h28
`define CAM_BIT_REGOK_MASK 7
`define CAM_BIT_CONV_MASK 6
`define CAM_BIT_SPARE_MASK 5
`define CAM_BIT_ERRHI_MASK 4
`define CAM_MASK5_WMASK 8'hd0
`define CAM_BIT_ENABLE 7
`define CAM_BIT_ONESHOT 6
`define CAM_BIT_AVERAGE 5
`define CAM_BIT_SEED 4
`define CAM_BIT_SPEED_HI 3
`define CAM_BIT_SPEED_LO 2
`define CAM_BIT_ICUR_OFF 1
`define CAM_BIT_VIN_OFF 0
`define CAM_RST_BYTE 8'h00
`define CAM_RST_WORD 16'h0000
`define CAM_SPEED_15 2'h0
`define CAM_SPEED_14 2'h1
`define CAM_SPEED_13 2'h2
`define CAM_SPEED_11 2'h3
`define CAM_ICUR_SC_OFS_MA 66
`define CAM_ICUR_SC_STEP_UA 997.2
`define CAM_ICUR_BP_OFS_MA 64
`define CAM_ICUR_BP_STEP_UA 1027.9
`define CAM_ICUR_MAX_MA 7000
`define CAM_VIN_OFS_MV 0
`define CAM_VIN_STEP_UV 1002.0
`define CAM_VIN_MAX_MV 16385
`define CAM_SETTLE_NS 200
`define CAM_SETTLE_CYC ((`CAM_SETTLE_NS + 19) / 20)
`endif

// ### include/cam_pkg.sv
// Types shared by the monitor control block
package cam_pkg;
    // Register access request from the management bus engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cam_req_t;
    // Event flags that can raise the interrupt
    typedef struct packed {
        logic regulator_ok_flag;
        logic converter_running_flag;
        logic input_error_high_flag;
    } cam_flags_t;
    // Conversion controls given to the sequencer
    typedef struct packed {
        logic enable;
        logic one_shot;
        logic averaging_select;
        logic average_seed_select;
        logic [1:0] sample_speed;
        logic input_current_ch_off;
        logic input_voltage_ch_off;
    } cam_ctrl_t;
    // Sequencer states, gray along the usual path
    typedef enum logic [1:0] {
        CAM_IDLE = 2'b00,
        CAM_ICUR = 2'b01,
        CAM_VIN = 2'b11,
        CAM_DONE = 2'b10
    } cam_state_t;
endpackage

// ### logic/cam_avg.sv
// Running-average filter for one converted channel
`timescale 1ns/1ns
module cam_avg #(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic clear_in,
    input wire logic load_in,
    input wire logic average_in,
    input wire logic seed_new_in,
    input wire logic first_in,
    input wire logic [WIDTH-1:0] sample_in,
    output logic [WIDTH-1:0] value_out
);
    import cam_pkg::*;
    logic [WIDTH-1:0] value_q; // Held result
    logic [WIDTH-1:0] value_d; // Next result
    logic [WIDTH:0] sum; // Sum of old and new

    // Averaging needs at least two bits
    if (WIDTH < 2) begin : g_width_chk
        $error("cam_avg width too small");
    end

    // Next result: plain sample, seed, or mean of old and new
    always_comb begin
        sum = {1'b0, value_q} + {1'b0, sample_in};
        value_d = value_q;
        if (clear_in) begin
            value_d = '0;
        end else if (load_in) begin
            if (!average_in) begin
                value_d = sample_in;
            end else if (first_in && seed_new_in) begin
                value_d = sample_in;
            end else begin
                value_d = sum[WIDTH:1];
            end
        end
    end

    // Result register
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            value_q <= '0;
        end else begin
            value_q <= value_d;
        end
    end

    assign value_out = value_q;
endmodule

// ### logic/cam_seq.sv
// Conversion sequencer that walks the two input channels
`timescale 1ns/1ns
`include "cam_map.svh"
module cam_seq (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire cam_pkg::cam_ctrl_t ctrl_in,
    input wire logic start_in,
    output logic icur_take_out,
    output logic vin_take_out,
    output logic pass_done_out,
    output logic running_out
);
    import cam_pkg::*;
    cam_state_t state_q; // Current state
    cam_state_t state_d; // Next state
    logic [7:0] cnt_q; // Settle counter
    logic [7:0] cnt_d;
    localparam logic [7:0] SETTLE = 8'(`CAM_SETTLE_CYC);

    // Settle time scales with resolution: fewer bits finish sooner
    function automatic logic [7:0] settle_for(input logic [1:0] speed);
        unique case (speed)
            `CAM_SPEED_15: settle_for = 8'(SETTLE << 2);
            `CAM_SPEED_14: settle_for = 8'(SETTLE << 1);
            `CAM_SPEED_13: settle_for = SETTLE;
            `CAM_SPEED_11: settle_for = 8'(SETTLE >> 1);
        endcase
    endfunction

    // Next state and counter
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (!ctrl_in.enable) begin
            state_d = CAM_IDLE;
            cnt_d = '0;
        end else begin
            unique case (state_q)
                CAM_IDLE: begin
                    if (start_in) begin
                        state_d = CAM_ICUR;
                        cnt_d = settle_for(ctrl_in.sample_speed);
                    end
                end
                CAM_ICUR: begin
                    if (ctrl_in.input_current_ch_off || cnt_q == 8'h00) begin
                        state_d = CAM_VIN;
                        cnt_d = settle_for(ctrl_in.sample_speed);
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
                CAM_VIN: begin
                    if (ctrl_in.input_voltage_ch_off || cnt_q == 8'h00) begin
                        state_d = CAM_DONE;
                    end else begin
                        cnt_d = cnt_q - 8'h01;
                    end
                end
                CAM_DONE: begin
                    state_d = ctrl_in.one_shot ? CAM_IDLE : CAM_ICUR;
                    cnt_d = settle_for(ctrl_in.sample_speed);
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= CAM_IDLE;
            cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign icur_take_out = state_q == CAM_ICUR && cnt_q == 8'h00
        && !ctrl_in.input_current_ch_off && ctrl_in.enable;
    assign vin_take_out = state_q == CAM_VIN && cnt_q == 8'h00
        && !ctrl_in.input_voltage_ch_off && ctrl_in.enable;
    assign pass_done_out = state_q == CAM_DONE;
    assign running_out = state_q != CAM_IDLE;
endmodule

// ### logic/cam_top.sv
// Monitor converter control registers and result holding for the charger
`timescale 1ns/1ns
`include "cam_map.svh"
module cam_top #(
    parameter logic [3:0] REVISION = 4'h1, // Arbitrary value
    parameter logic [3:0] IDENT = 4'h5, // Arbitrary value
    parameter int SAMPLE_W = 16
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire cam_pkg::cam_req_t req_in,
    output logic [7:0] rdata_out,
    input wire logic reg_reset_in,
    input wire logic watchdog_expired_in,
    input wire cam_pkg::cam_flags_t flags_in,
    input wire logic bypass_mode_in,
    input wire logic [SAMPLE_W-1:0] icur_raw_in,
    input wire logic [SAMPLE_W-1:0] vin_raw_in,
    output logic irq_n_out,
    output cam_pkg::cam_ctrl_t ctrl_out,
    output logic [7:0] channel_off_out,
    output logic [3:0] resolution_bits_out,
    output logic converter_running_out
);
    import cam_pkg::*;
    // Host-visible register bytes and captured read data
    logic [7:0] mask_q; // Interrupt mask byte
    logic [7:0] mask_d;
    logic [7:0] ctrl1_q; // First control byte
    logic [7:0] ctrl1_d;
    logic [7:0] ctrl2_q; // Channel disable byte
    logic [7:0] ctrl2_d;
    logic [7:0] rdata_q; // Read data
    logic [7:0] rdata_d;
    // Result words and the current sample in switched-cap scale
    logic [SAMPLE_W-1:0] icur_val; // Current result
    logic [SAMPLE_W-1:0] vin_val; // Voltage result
    logic [SAMPLE_W-1:0] icur_scaled; // Mode-corrected current sample
    // Seed tracking, one flag per channel
    logic icur_first_q; // First average sample pending
    logic vin_first_q;
    logic icur_first_d;
    logic vin_first_d;
    // Strobes and status from the sequencer
    logic icur_take; // Current sample strobe
    logic vin_take; // Voltage sample strobe
    logic pass_done; // Pass finished
    logic running; // Sequencer busy
    // Start pulse and interrupt line
    logic start_q; // Start request
    logic start_d;
    logic irq_n_q; // Registered interrupt, low active
    logic irq_n_d;
    logic [2:0] irq_open; // Unmasked raised flags
    logic ctrl1_wr; // Host writes the first control byte
    // Decoded first control byte
    cam_ctrl_t ctrl;

    // Results are 16-bit registers; the byte lanes below assume it
    // A wider result would need more byte offsets
    if (SAMPLE_W != 16) begin : g_width_chk
        $error("cam_top needs 16-bit results");
    end

    // Offset in counts between the two current modes
    // Only the fixed offset is corrected; the step differs by about three
    // percent between modes and is left to host software
    localparam logic [SAMPLE_W-1:0] MODE_DELTA =
        SAMPLE_W'(`CAM_ICUR_SC_OFS_MA - `CAM_ICUR_BP_OFS_MA);

    // Read-data mux for a register offset
    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        // Result halves are read live: no snapshot ties the two bytes
        // Unmapped offsets read zero so probing is harmless
        // Identification is fixed when the block is built
        unique case (addr)
            `CAM_OFF_MASK5: reg_read = mask_q & `CAM_MASK5_WMASK;
            `CAM_OFF_IDENT: reg_read = {REVISION, IDENT};
            `CAM_OFF_CTRL1: reg_read = ctrl1_q;
            `CAM_OFF_CTRL2: reg_read = ctrl2_q;
            `CAM_OFF_ICUR_HI: reg_read = icur_val[15:8];
            `CAM_OFF_ICUR_LO: reg_read = icur_val[7:0];
            `CAM_OFF_VIN_HI: reg_read = vin_val[15:8];
            `CAM_OFF_VIN_LO: reg_read = vin_val[7:0];
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Map speed code to result bit count
    function automatic logic [3:0] res_bits(input logic [1:0] speed);
        // Reported width only; every two-bit code is legal
        // Settle time follows the same code in the sequencer
        unique case (speed)
            `CAM_SPEED_15: res_bits = 4'hf;
            `CAM_SPEED_14: res_bits = 4'he;
            `CAM_SPEED_13: res_bits = 4'hd;
            `CAM_SPEED_11: res_bits = 4'hb;
        endcase
    endfunction

    // Control fields unpacked from the first control byte
    // Struct order matches the byte, enable in the top bit
    always_comb begin
        ctrl.enable = ctrl1_q[`CAM_BIT_ENABLE];
        ctrl.one_shot = ctrl1_q[`CAM_BIT_ONESHOT];
        ctrl.averaging_select = ctrl1_q[`CAM_BIT_AVERAGE];
        ctrl.average_seed_select = ctrl1_q[`CAM_BIT_SEED];
        ctrl.sample_speed = ctrl1_q[`CAM_BIT_SPEED_HI:`CAM_BIT_SPEED_LO];
        ctrl.input_current_ch_off = ctrl1_q[`CAM_BIT_ICUR_OFF];
        ctrl.input_voltage_ch_off = ctrl1_q[`CAM_BIT_VIN_OFF];
    end

    // Register writes, clears and read data
    always_comb begin
        // Defaults: hold every byte, no start
        mask_d = mask_q;
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        rdata_d = rdata_q;
        start_d = 1'b0;
        // Register-reset command wins over a write in the same cycle
        if (reg_reset_in) begin
            mask_d = `CAM_RST_BYTE;
            ctrl1_d = `CAM_RST_BYTE;
            ctrl2_d = `CAM_RST_BYTE;
        end else begin
            // Host write, decoded by offset
            if (req_in.wr) begin
                unique case (req_in.addr)
                    `CAM_OFF_MASK5: begin
                        // Reserved mask bits never store
                        mask_d = req_in.wdata & `CAM_MASK5_WMASK;
                    end
                    `CAM_OFF_CTRL1: begin
                        ctrl1_d = req_in.wdata;
                        // Setting enable starts a pass on the next cycle
                        start_d = req_in.wdata[`CAM_BIT_ENABLE];
                    end
                    `CAM_OFF_CTRL2: begin
                        // Stored only; those channels live elsewhere
                        ctrl2_d = req_in.wdata;
                    end
                    default: begin
                        // Read-only or unmapped: write ignored
                    end
                endcase
            end
            // Watchdog expiry drops enable only; other fields keep
            if (watchdog_expired_in) begin
                ctrl1_d[`CAM_BIT_ENABLE] = 1'b0;
                start_d = 1'b0;
            end
            // One-shot pass over: enable drops itself, unless a host write of the first control byte
            // lands in the same cycle, which must not lose its start
            if (pass_done && ctrl.one_shot && !ctrl1_wr) begin
                ctrl1_d[`CAM_BIT_ENABLE] = 1'b0;
            end
        end
        // Read data captured at the request edge, held until the next read
        if (req_in.rd) begin
            rdata_d = reg_read(req_in.addr);
        end
    end

    // Seed tracking for averaging
    always_comb begin
        icur_first_d = icur_first_q;
        vin_first_d = vin_first_q;
        // A new start or a register reset re-arms seeding
        if (start_q || reg_reset_in) begin
            icur_first_d = 1'b1;
            vin_first_d = 1'b1;
        end
        // The first taken sample of each channel consumes its seed
        if (icur_take) begin
            icur_first_d = 1'b0;
        end
        if (vin_take) begin
            vin_first_d = 1'b0;
        end
    end

    // Bypass mode has lower offset in counts; re-express in switched-cap scale
    // Correction comes before averaging, so both modes average alike
    // Codes within two counts of full scale wrap; readings stay far below
    always_comb begin
        if (bypass_mode_in) begin
            icur_scaled = icur_raw_in + MODE_DELTA;
        end else begin
            icur_scaled = icur_raw_in;
        end
    end

    // Interrupt: unmasked flags pull the line low
    // Registered so the pin does not glitch while mask bits change
    // Level, not sticky: the line rises one clock after the flags drop
    always_comb begin
        // Regulator-good term
        irq_open[2] = flags_in.regulator_ok_flag && !mask_q[`CAM_BIT_REGOK_MASK];
        // Converter-running term
        irq_open[1] = flags_in.converter_running_flag && !mask_q[`CAM_BIT_CONV_MASK];
        // Input-error-high term
        irq_open[0] = flags_in.input_error_high_flag && !mask_q[`CAM_BIT_ERRHI_MASK];
        // Any open term pulls the line low
        irq_n_d = !(|irq_open);
    end

    // Register file storage
    // Reset values equal those of the register-reset command
    // Seed flags start armed, so the first sample after reset seeds
    // Read data resets to zero, as an unmapped read
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mask_q <= `CAM_RST_BYTE;
            ctrl1_q <= `CAM_RST_BYTE;
            ctrl2_q <= `CAM_RST_BYTE;
            rdata_q <= `CAM_RST_BYTE;
            start_q <= 1'b0;
            icur_first_q <= 1'b1;
            vin_first_q <= 1'b1;
            irq_n_q <= 1'b1;
        end else begin
            mask_q <= mask_d;
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            rdata_q <= rdata_d;
            start_q <= start_d;
            icur_first_q <= icur_first_d;
            vin_first_q <= vin_first_d;
            irq_n_q <= irq_n_d;
        end
    end

    // Conversion sequencer
    // Reads the decoded controls live; each strobe lasts one cycle
    cam_seq u_seq (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .ctrl_in(ctrl),
        .start_in(start_q),
        .icur_take_out(icur_take),
        .vin_take_out(vin_take),
        .pass_done_out(pass_done),
        .running_out(running)
    );

    // Current result holder
    // Register reset clears the held value at the same edge
    cam_avg #(.WIDTH(SAMPLE_W)) u_icur (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .clear_in(reg_reset_in),
        .load_in(icur_take),
        .average_in(ctrl.averaging_select),
        .seed_new_in(ctrl.average_seed_select),
        .first_in(icur_first_q),
        .sample_in(icur_scaled),
        .value_out(icur_val)
    );

    // Voltage result holder
    // Raw voltage needs no mode correction
    cam_avg #(.WIDTH(SAMPLE_W)) u_vin (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .clear_in(reg_reset_in),
        .load_in(vin_take),
        .average_in(ctrl.averaging_select),
        .seed_new_in(ctrl.average_seed_select),
        .first_in(vin_first_q),
        .sample_in(vin_raw_in),
        .value_out(vin_val)
    );

    // Same-cycle host write of the first control byte
    assign ctrl1_wr = req_in.wr && req_in.addr == `CAM_OFF_CTRL1;
    // Outputs come from registers or a decode of them
    assign rdata_out = rdata_q;
    assign irq_n_out = irq_n_q;
    assign ctrl_out = ctrl;
    assign channel_off_out = ctrl2_q;
    assign resolution_bits_out = res_bits(ctrl.sample_speed);
    assign converter_running_out = running;
endmodule

// ### bench/cam_top_props.sv
// Port-level checker for the monitor control block
`timescale 1ns/1ns
module cam_top_props #(
    parameter logic [3:0] REVISION = 4'h1,
    parameter logic [3:0] IDENT = 4'h5
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire cam_pkg::cam_req_t req_in,
    input wire logic [7:0] rdata_out,
    input wire logic reg_reset_in,
    input wire logic watchdog_expired_in,
    input wire cam_pkg::cam_flags_t flags_in,
    input wire logic irq_n_out,
    input wire cam_pkg::cam_ctrl_t ctrl_out,
    input wire logic [7:0] channel_off_out,
    input wire logic [3:0] resolution_bits_out,
    input wire logic converter_running_out
);
    import cam_pkg::*;
    // One clock domain, reset disables everything
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    // Speed code maps to 15, 14, 13, 11 bits
    property p_res;
        resolution_bits_out == (ctrl_out.sample_speed == 2'h0 ? 4'hf :
            ctrl_out.sample_speed == 2'h1 ? 4'he : ctrl_out.sample_speed == 2'h2 ? 4'hd : 4'hb);
    endproperty
    a_res: assert property (p_res) else $error("resolution does not follow speed code");
    // No raised flag means the interrupt line rests high
    property p_irq_quiet;
        flags_in == 3'b000 |=> irq_n_out;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");
    // Channel disables follow the written byte
    property p_chan_wr;
        req_in.wr && req_in.addr == 8'h24 && !reg_reset_in |=>
            channel_off_out == $past(req_in.wdata);
    endproperty
    a_chan_wr: assert property (p_chan_wr) else $error("channel disables not written");
    // Mode, averaging, seed, speed and channel bits follow the written byte
    property p_ctrl_wr;
        req_in.wr && req_in.addr == 8'h23 && !reg_reset_in && !watchdog_expired_in |=>
            ctrl_out[6:0] == $past(req_in.wdata[6:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl bits");
    // Watchdog expiry clears enable and stops the sequencer
    property p_wd;
        watchdog_expired_in && !req_in.wr |=> !ctrl_out.enable ##[0:3] !converter_running_out;
    endproperty
    a_wd: assert property (p_wd) else $error("watchdog left converter enabled");
    // Register reset clears both control registers
    property p_regrst;
        reg_reset_in |=> ctrl_out == 8'h00 && channel_off_out == 8'h00;
    endproperty
    a_regrst: assert property (p_regrst) else $error("reset left control set");
    // Identification reads revision high, identifier low
    property p_ident;
        req_in.rd && req_in.addr == 8'h22 |=> rdata_out == {REVISION, IDENT};
    endproperty
    a_ident: assert property (p_ident) else $error("identification read wrong");
    // Reserved mask bits read zero
    property p_mask_rd;
        req_in.rd && req_in.addr == 8'h21 |=> rdata_out[3:0] == 4'h0 && !rdata_out[5];
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("reserved mask bits not zero");
    // Enabling the converter starts the sequencer
    property p_start;
        $rose(ctrl_out.enable) |-> ##[0:3] converter_running_out;
    endproperty
    a_start: assert property (p_start) else $error("sequencer did not start");
    // Main scenarios reached
    c_irq: cover property (!irq_n_out);
    c_run: cover property ($rose(converter_running_out));
    c_wd: cover property (watchdog_expired_in && converter_running_out);
endmodule
bind cam_top cam_top_props #(.REVISION(REVISION), .IDENT(IDENT)) cam_top_props_i (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req_in), .rdata_out(rdata_out),
    .reg_reset_in(reg_reset_in), .watchdog_expired_in(watchdog_expired_in),
    .flags_in(flags_in), .irq_n_out(irq_n_out), .ctrl_out(ctrl_out),
    .channel_off_out(channel_off_out), .resolution_bits_out(resolution_bits_out),
    .converter_running_out(converter_running_out));

// ### bench/test_cam_top.sv
// Directed register-level bench for the monitor control block
`timescale 1ns/1ns
module test_cam_top;
    import cam_pkg::*;
    logic clk_sys_in = 1'b0; // System clock
    logic nrst_in = 1'b0; // Reset, active low
    cam_req_t req_in = '0; // Register request
    logic reg_reset_in = 1'b0; // Register-reset command
    logic watchdog_expired_in = 1'b0; // Watchdog expiry
    cam_flags_t flags_in = '0; // Event flags
    logic bypass_mode_in = 1'b0; // Low is switched-cap mode
    logic [15:0] icur_raw_in = 16'h0000; // Raw current code
    logic [15:0] vin_raw_in = 16'h0000; // Raw voltage code
    logic [7:0] rdata_out;
    logic irq_n_out;
    cam_ctrl_t ctrl_out;
    logic [7:0] channel_off_out;
    logic [3:0] resolution_bits_out;
    logic converter_running_out;
    int miscompares = 0; // Mismatch count
    int checked = 0; // Comparison count
    int i;
    logic [7:0] mb [3] = '{8'h80, 8'h40, 8'h10}; // Mask bit of each flag
    logic [3:0] rb [4] = '{4'hf, 4'he, 4'hd, 4'hb}; // Resolution of each code
    // 50 MHz clock
    always #10 clk_sys_in = ~clk_sys_in;
    cam_top #(.REVISION(4'h3), .IDENT(4'ha)) cam_top_i (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .req_in(req_in), .rdata_out(rdata_out), .reg_reset_in(reg_reset_in),
        .watchdog_expired_in(watchdog_expired_in), .flags_in(flags_in),
        .bypass_mode_in(bypass_mode_in), .icur_raw_in(icur_raw_in), .vin_raw_in(vin_raw_in),
        .irq_n_out(irq_n_out), .ctrl_out(ctrl_out), .channel_off_out(channel_off_out),
        .resolution_bits_out(resolution_bits_out), .converter_running_out(converter_running_out));
    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One-cycle write pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys_in);
        req_in = '0;
    endtask
    // One-cycle read pulse, data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_sys_in);
        req_in = '0;
        d = rdata_out;
    endtask
    // Read a register, results as high then low byte
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [7:0] hi;
        logic [7:0] lo;
        rd(a, hi);
        lo = hi;
        if (a == 8'h25 || a == 8'h27) begin
            rd(a + 8'h01, lo);
            hi = hi;
        end else begin
            hi = 8'h00;
        end
        check($sformatf("reg %h", a), {hi, lo}, exp);
    endtask
    // Reset values of every register and an unmapped place
    task automatic all_reset();
        rchk(8'h21, 16'h0000);
        rchk(8'h22, 16'h003a);
        rchk(8'h23, 16'h0000);
        rchk(8'h24, 16'h0000);
        rchk(8'h25, 16'h0000);
        rchk(8'h27, 16'h0000);
        rchk(8'h30, 16'h0000);
    endtask
    // Start a pass and wait for the sequencer to finish
    task automatic run(input logic [7:0] c);
        int n;
        wr(8'h23, c);
        for (n = 0; n < 10 && converter_running_out !== 1'b1; n++) @(negedge clk_sys_in);
        for (n = 0; n < 400 && converter_running_out !== 1'b0; n++) @(negedge clk_sys_in);
        check("pass end", converter_running_out, 16'h0000);
    endtask
    // Print counts and verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    // Test sequence
    initial begin
        repeat (3) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        check("irq rest", irq_n_out, 16'h0001);
        check("resolution", resolution_bits_out, 16'h000f);
        all_reset();
        $display("test reset done");
        wr(8'h21, 8'hff);
        rchk(8'h21, 16'h00d0);
        for (i = 0; i < 3; i++) begin
            flags_in = cam_flags_t'(3'b100 >> i);
            wr(8'h21, mb[i]);
            @(negedge clk_sys_in);
            check("irq masked", irq_n_out, 16'h0001);
            wr(8'h21, 8'hd0 ^ mb[i]);
            @(negedge clk_sys_in);
            check("irq open", irq_n_out, 16'h0000);
        end
        flags_in = '0;
        wr(8'h22, 8'hff);
        rchk(8'h22, 16'h003a);
        wr(8'h27, 8'hff);
        rchk(8'h27, 16'h0000);
        $display("test mask done");
        wr(8'h24, 8'ha5);
        check("chan", channel_off_out, 16'h00a5);
        rchk(8'h24, 16'h00a5);
        for (i = 0; i < 4; i++) begin
            wr(8'h23, 8'h73 | 8'(i << 2));
            check("ctrl", ctrl_out, 16'h0073 | 16'(i << 2));
            check("res", resolution_bits_out, rb[i]);
        end
        wr(8'h24, 8'h00);
        $display("test control done");
        icur_raw_in = 16'h1234;
        vin_raw_in = 16'h0567;
        run(8'hcc);
        rchk(8'h25, 16'h1234);
        rchk(8'h27, 16'h0567);
        rchk(8'h23, 16'h004c);
        bypass_mode_in = 1'b1;
        run(8'hcc);
        rchk(8'h25, 16'h1236);
        bypass_mode_in = 1'b0;
        icur_raw_in = 16'h1000;
        vin_raw_in = 16'h0101;
        run(8'hec);
        rchk(8'h25, 16'h111b);
        rchk(8'h27, 16'h0334);
        icur_raw_in = 16'h2000;
        run(8'hfc);
        rchk(8'h25, 16'h2000);
        icur_raw_in = 16'h3000;
        vin_raw_in = 16'h0200;
        run(8'hce);
        rchk(8'h25, 16'h2000);
        rchk(8'h27, 16'h0200);
        vin_raw_in = 16'h0300;
        run(8'hcd);
        rchk(8'h25, 16'h3000);
        rchk(8'h27, 16'h0200);
        $display("test conversion done");
        wr(8'h23, 8'h8c);
        for (i = 0; i < 10 && converter_running_out !== 1'b1; i++) @(negedge clk_sys_in);
        repeat (20) @(negedge clk_sys_in);
        check("continuous", converter_running_out, 16'h0001);
        watchdog_expired_in = 1'b1;
        @(negedge clk_sys_in);
        watchdog_expired_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        check("running", converter_running_out, 16'h0000);
        rchk(8'h23, 16'h000c);
        $display("test watchdog done");
        wr(8'h21, 8'hd0);
        wr(8'h23, 8'hbf);
        @(negedge clk_sys_in);
        reg_reset_in = 1'b1;
        req_in = '{wr: 1'b1, rd: 1'b0, addr: 8'h24, wdata: 8'h55};
        @(negedge clk_sys_in);
        reg_reset_in = 1'b0;
        req_in = '0;
        check("chan", channel_off_out, 16'h0000);
        all_reset();
        $display("test register reset done");
        conclude();
    end
endmodule
